// File: core/rtdc_top.sv
// The plain strobed port was left to the implementer.
`include "rtdc_regs.svh"
`default_nettype none

module rtdc_top (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    // Modulation sources
    input wire logic internal_envelope_signal_i,
    input wire logic external_signal_input_i,
    input wire logic first_carrier_i,
    // Driver pins
    output logic first_driver_pin_o,
    output logic second_driver_pin_o,
    output logic driver_pins_enable_o,
    output rtdc_pkg::rtdc_mode_t driver_output_mode_o,
    // Analog and sequencer settings
    output logic [10:0] carrier_level_reduction_o,
    output logic carrier_max_o,
    output logic [4:0] residual_carrier_o,
    output logic [3:0] overshoot_guard_length_o,
    output logic modulation_o
);
    import rtdc_pkg::*;

    logic [7:0] driver_mode_q;
    logic [7:0] carrier_amplitude_q;
    logic [7:0] transmitter_control_q;
    logic [2:0] ext_sync_q;
    logic ext_level_q;
    logic mod_sel;
    logic mod_d;
    rtdc_src_t src;

    // Millivolt reduction for a code
    function automatic logic [10:0] red_mv(input logic [1:0] code);
        unique case (code)
            2'h0: red_mv = `RTDC_RED_MV_0;
            2'h1: red_mv = `RTDC_RED_MV_1;
            2'h2: red_mv = `RTDC_RED_MV_2;
            2'h3: red_mv = `RTDC_RED_MV_3;
        endcase
    endfunction

    // Driver mode register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            driver_mode_q <= `RTDC_DRIVER_MODE_RST;
        end else if (reg_we_i && reg_addr_i == `RTDC_DRIVER_MODE_OFS) begin
            driver_mode_q <= reg_wdata_i & `RTDC_DM_WRITE_MASK;
        end
    end

    // Carrier amplitude register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            carrier_amplitude_q <= `RTDC_CARRIER_AMPLITUDE_RST;
        end else if (reg_we_i &&
                     reg_addr_i == `RTDC_CARRIER_AMPLITUDE_OFS) begin
            carrier_amplitude_q <= reg_wdata_i & `RTDC_CA_WRITE_MASK;
        end
    end

    // Transmitter control register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            transmitter_control_q <= `RTDC_TRANSMITTER_CONTROL_RST;
        end else if (reg_we_i &&
                     reg_addr_i == `RTDC_TRANSMITTER_CONTROL_OFS) begin
            transmitter_control_q <= reg_wdata_i;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_re_i) begin
            unique case (reg_addr_i)
                `RTDC_DRIVER_MODE_OFS: reg_rdata_o <= driver_mode_q;
                `RTDC_CARRIER_AMPLITUDE_OFS: reg_rdata_o <= carrier_amplitude_q;
                `RTDC_TRANSMITTER_CONTROL_OFS:
                    reg_rdata_o <= transmitter_control_q;
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // External input synchroniser, three stages
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ext_sync_q <= 3'h0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], external_signal_input_i};
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ext_level_q <= 1'b0;
        end else if (ext_sync_q[1] == ext_sync_q[2]) begin
            ext_level_q <= ext_sync_q[2];
        end
    end

    // Modulation source selection
    always_comb begin
        src = rtdc_src_t'(transmitter_control_q[`RTDC_TC_SEL_MSB:0]);
        unique case (src)
            RTDC_SRC_NONE: mod_sel = 1'b0;
            RTDC_SRC_ENVELOPE: mod_sel = internal_envelope_signal_i;
            RTDC_SRC_EXTERNAL: mod_sel = ext_level_q;
            RTDC_SRC_RESERVED: mod_sel = 1'b0;
        endcase
        mod_d = mod_sel ^ transmitter_control_q[`RTDC_TC_INV_BIT];
    end

    // Registered modulation and driver pins
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            modulation_o <= 1'b0;
            first_driver_pin_o <= 1'b0;
            second_driver_pin_o <= 1'b0;
        end else begin
            modulation_o <= mod_d;
            first_driver_pin_o <= driver_mode_q[`RTDC_DM_ENABLE_BIT] &
                (first_carrier_i ^ driver_mode_q[`RTDC_DM_FIRST_INV_BIT]);
            second_driver_pin_o <= driver_mode_q[`RTDC_DM_ENABLE_BIT] &
                (first_carrier_i ^ driver_mode_q[`RTDC_DM_SECOND_INV_BIT]);
        end
    end
    // above: pins gated by enable, each with its own inversion

    // Static settings straight from the registers
    assign driver_pins_enable_o = driver_mode_q[`RTDC_DM_ENABLE_BIT];
    assign driver_output_mode_o = driver_mode_q[`RTDC_DM_MODE_MSB:0];
    assign carrier_max_o = transmitter_control_q[`RTDC_TC_MAX_BIT];
    // Max carrier removes any reduction
    assign carrier_level_reduction_o = carrier_max_o ? 11'h000 :
        red_mv(carrier_amplitude_q[`RTDC_CA_RED_MSB:`RTDC_CA_RED_LSB]);
    assign residual_carrier_o =
        carrier_amplitude_q[`RTDC_CA_RES_MSB:0];
    assign overshoot_guard_length_o =
        transmitter_control_q[`RTDC_TC_GUARD_MSB:`RTDC_TC_GUARD_LSB];

    // Pins stay low while the drivers are disabled
    a_pin_one_disable: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !$past(driver_mode_q[3]) |-> !first_driver_pin_o)
        else $error("first pin active while disabled");

    a_pin_two_disable: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !$past(driver_mode_q[3]) |-> !second_driver_pin_o)
        else $error("second pin active while disabled");

    // Each pin follows the carrier through its own inversion
    a_pin_one_inv: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $past(!rst_i && driver_mode_q[3]) |->
        first_driver_pin_o ==
        ($past(first_carrier_i) ^ $past(driver_mode_q[6])))
        else $error("first pin inversion wrong");

    a_pin_two_inv: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $past(!rst_i && driver_mode_q[3]) |->
        second_driver_pin_o ==
        ($past(first_carrier_i) ^ $past(driver_mode_q[7])))
        else $error("second pin inversion wrong");

    // Static settings mirror their register fields
    a_enable_flag: assert property (@(posedge core_clk_i)
        disable iff (rst_i) driver_pins_enable_o == driver_mode_q[3])
        else $error("enable output differs from its bit");

    a_mode_field: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        $past(!rst_i && reg_we_i && reg_addr_i == 8'h28) |->
        driver_output_mode_o == $past(reg_wdata_i[2:0]))
        else $error("mode field not written");

    // Amplitude reduction and its override
    a_max_carrier: assert property (@(posedge core_clk_i)
        disable iff (rst_i) carrier_max_o |-> carrier_level_reduction_o == 0)
        else $error("reduction active under max carrier");

    a_max_flag: assert property (@(posedge core_clk_i)
        disable iff (rst_i) carrier_max_o == transmitter_control_q[3])
        else $error("max carrier flag differs from its bit");

    a_red_code_zero: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (!carrier_max_o && carrier_amplitude_q[7:6] == 0)
        |-> carrier_level_reduction_o == 11'h064)
        else $error("reduction code zero wrong");

    a_red_code_one: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (!carrier_max_o && carrier_amplitude_q[7:6] == 1)
        |-> carrier_level_reduction_o == 11'h0FA)
        else $error("reduction code one wrong");

    a_red_code_two: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (!carrier_max_o && carrier_amplitude_q[7:6] == 2)
        |-> carrier_level_reduction_o == 11'h1F4)
        else $error("reduction code two wrong");

    a_red_code_three: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (!carrier_max_o && carrier_amplitude_q[7:6] == 3)
        |-> carrier_level_reduction_o == 11'h3E8)
        else $error("reduction code three wrong");

    a_residual: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $past(!rst_i && reg_we_i && reg_addr_i == 8'h29)
        |-> residual_carrier_o == $past(reg_wdata_i[4:0]))
        else $error("residual not written");

    // Guard length field, then the modulation path one cycle behind its source
    a_guard_len: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $past(!rst_i && reg_we_i && reg_addr_i == 8'h2A)
        |-> overshoot_guard_length_o == $past(reg_wdata_i[7:4]))
        else $error("guard length not written");

    a_mod_none: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $past(transmitter_control_q[1:0]) == 0 |->
        modulation_o == $past(transmitter_control_q[2]))
        else $error("no-source modulation wrong");

    a_mod_env: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $past(transmitter_control_q[1:0]) == 1 |->
        modulation_o == ($past(internal_envelope_signal_i) ^
        $past(transmitter_control_q[2])))
        else $error("envelope modulation wrong");

    a_mod_ext: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $past(transmitter_control_q[1:0]) == 2 |->
        modulation_o == ($past(ext_level_q) ^
        $past(transmitter_control_q[2])))
        else $error("external modulation wrong");

    a_mod_reserved: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $past(transmitter_control_q[1:0]) == 3 |->
        modulation_o == $past(transmitter_control_q[2]))
        else $error("reserved source not silent");

    a_ext_filter: assert property (@(posedge core_clk_i)
        disable iff (rst_i) ext_level_q != $past(ext_level_q) |->
        $past(ext_sync_q[1]) == $past(ext_sync_q[2]))
        else $error("external level moved without agreement");

    // Register port
    a_reserved_zero: assert property (@(posedge core_clk_i)
        disable iff (rst_i) driver_mode_q[5:4] == 0 &&
        carrier_amplitude_q[5] == 0)
        else $error("reserved bit stored");

    a_rdata_idle: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !$past(reg_re_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside its cycle");

    a_rdata_unmapped: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $past(!rst_i && reg_re_i &&
        reg_addr_i != 8'h28 && reg_addr_i != 8'h29 &&
        reg_addr_i != 8'h2A) |-> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");

    a_rdata_mode: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        $past(!rst_i && reg_re_i && reg_addr_i == 8'h28) |->
        reg_rdata_o == $past(driver_mode_q))
        else $error("driver mode read wrong");

    a_rdata_amp: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        $past(!rst_i && reg_re_i && reg_addr_i == 8'h29) |->
        reg_rdata_o == $past(carrier_amplitude_q))
        else $error("carrier amplitude read wrong");

    a_rdata_ctrl: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        $past(!rst_i && reg_re_i && reg_addr_i == 8'h2A) |->
        reg_rdata_o == $past(transmitter_control_q))
        else $error("transmitter control read wrong");

    a_ctrl_written: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        $past(!rst_i && reg_we_i && reg_addr_i == 8'h2A) |->
        transmitter_control_q == $past(reg_wdata_i))
        else $error("transmitter control not written");

    a_amp_written: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        $past(!rst_i && reg_we_i && reg_addr_i == 8'h29) |->
        carrier_amplitude_q == ($past(reg_wdata_i) & 8'hDF))
        else $error("carrier amplitude not written");

    // Registers hold unless their own address is written
    a_mode_kept: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !$past(rst_i || reg_we_i && reg_addr_i == 8'h28)
        |-> $stable(driver_mode_q))
        else $error("driver mode changed without a write");

    a_amp_kept: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !$past(rst_i || reg_we_i && reg_addr_i == 8'h29)
        |-> $stable(carrier_amplitude_q))
        else $error("carrier amplitude changed without a write");

    a_ctrl_kept: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !$past(rst_i || reg_we_i && reg_addr_i == 8'h2A)
        |-> $stable(transmitter_control_q))
        else $error("transmitter control changed without a write");

    // Main scenarios
    c_enable_write: cover property (@(posedge core_clk_i)
        disable iff (rst_i) $rose(driver_pins_enable_o));

    c_ext_source: cover property (@(posedge core_clk_i)
        disable iff (rst_i) transmitter_control_q[1:0] == 2 && modulation_o);

    c_max_carrier: cover property (@(posedge core_clk_i)
        disable iff (rst_i) carrier_max_o && carrier_amplitude_q[7:6] != 0);

    c_pins_inverted: cover property (@(posedge core_clk_i)
        disable iff (rst_i) driver_pins_enable_o && driver_mode_q[7:6] == 3);

    c_mod_inverted: cover property (@(posedge core_clk_i)
        disable iff (rst_i) transmitter_control_q[2:0] == 3'h5);
endmodule

`default_nettype wire

// File: inc/rtdc_regs.svh
`ifndef RTDC_REGS_SVH
`define RTDC_REGS_SVH

// Register offsets
`define RTDC_DRIVER_MODE_OFS 8'h28
`define RTDC_CARRIER_AMPLITUDE_OFS 8'h29
`define RTDC_TRANSMITTER_CONTROL_OFS 8'h2A

// Driver mode fields
`define RTDC_DM_SECOND_INV_BIT 7
`define RTDC_DM_FIRST_INV_BIT 6
`define RTDC_DM_ENABLE_BIT 3
`define RTDC_DM_MODE_MSB 2
`define RTDC_DM_WRITE_MASK 8'hCF

// Carrier amplitude fields
`define RTDC_CA_RED_MSB 7
`define RTDC_CA_RED_LSB 6
`define RTDC_CA_RES_MSB 4
`define RTDC_CA_WRITE_MASK 8'hDF

// Transmitter control fields
`define RTDC_TC_GUARD_MSB 7
`define RTDC_TC_GUARD_LSB 4
`define RTDC_TC_MAX_BIT 3
`define RTDC_TC_INV_BIT 2
`define RTDC_TC_SEL_MSB 1

// Reset values
`define RTDC_DRIVER_MODE_RST 8'h00
`define RTDC_CARRIER_AMPLITUDE_RST 8'h00
`define RTDC_TRANSMITTER_CONTROL_RST 8'h00

// Reduction in millivolts per code
`define RTDC_RED_MV_0 11'h064
`define RTDC_RED_MV_1 11'h0FA
`define RTDC_RED_MV_2 11'h1F4
`define RTDC_RED_MV_3 11'h3E8

`endif

// File: inc/rtdc_pkg.sv
package rtdc_pkg;
    // Modulation source codes
    typedef enum logic [1:0] {
        RTDC_SRC_NONE = 2'h0,
        RTDC_SRC_ENVELOPE = 2'h1,
        RTDC_SRC_EXTERNAL = 2'h2,
        RTDC_SRC_RESERVED = 2'h3
    } rtdc_src_t;
    typedef logic [2:0] rtdc_mode_t;
endpackage

// File: testbench/rtdc_carrier_model.sv
`default_nettype none
// Carrier source for the driver pins, level held by the bench
module rtdc_carrier_model (
    // Clock
    input wire logic clk_i,
    // Requested carrier level
    input wire logic level_i,
    // Carrier toward both pins
    output logic carrier_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Launch the level just after an edge, like the driver clock would
    always_ff @(posedge clk_i) begin
        carrier_o <= level_i;
    end
endmodule
`default_nettype wire

// File: testbench/rtdc_top_tb_top.sv
`default_nettype none
module rtdc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r;} rtdc_row_t;
    logic core_clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, re = 1'b0;
    logic env = 1'b0, ext = 1'b0, lvl = 1'b0, car, p1, p2, en, cmax, mod;
    logic [7:0] addr = 8'h00, wd = 8'h00, rd_q;
    logic [2:0] mode;
    logic [10:0] red;
    logic [4:0] resid;
    logic [3:0] guard;
    int n_errors = 0, check_count = 0;
    rtdc_row_t rows [7] = '{'{8'h28, 8'hFF, 8'hCF}, '{8'h29, 8'hFF, 8'hDF},
        '{8'h2A, 8'hFF, 8'hFF}, '{8'h30, 8'hFF, 8'h00},
        '{8'h28, 8'h35, 8'h05}, '{8'h29, 8'h3F, 8'h1F},
        '{8'h2A, 8'h52, 8'h52}};
    logic [10:0] mv [4] = '{11'h064, 11'h0FA, 11'h1F4, 11'h3E8};
    logic [8:0] pin_rows [6] = '{9'h008, 9'h049, 9'h08A, 9'h0C0, 9'h10F,
        9'h1C8};
    // Clock at 50 MHz
    always #10 core_clk_i = ~core_clk_i;
    rtdc_carrier_model model (.clk_i(core_clk_i), .level_i(lvl),
        .carrier_o(car));
    rtdc_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rd_q),
        .internal_envelope_signal_i(env), .external_signal_input_i(ext),
        .first_carrier_i(car), .first_driver_pin_o(p1),
        .second_driver_pin_o(p2), .driver_pins_enable_o(en),
        .driver_output_mode_o(mode), .carrier_level_reduction_o(red),
        .carrier_max_o(cmax), .residual_carrier_o(resid),
        .overshoot_guard_length_o(guard), .modulation_o(mod));
    // Compare and count
    task automatic chk(input logic [10:0] s, input logic [10:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One-cycle write strobe, effect settled after the closing edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        we <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge core_clk_i);
        we <= 1'b0;
        #1;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        re <= 1'b1;
        addr <= a;
        @(posedge core_clk_i);
        re <= 1'b0;
        #1;
        chk({3'h0, rd_q}, {3'h0, e});
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge core_clk_i);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        #1;
        chk({6'h00, p1, p2, en, cmax, mod}, 11'h000);
        chk(red, 11'h064);
        rd(8'h2A, 8'h00);
        // Write and read back every row, reserved bits dropped
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].r);
        end
        chk({8'h00, mode}, 11'h005);
        chk({6'h00, resid}, 11'h01F);
        chk({7'h00, guard}, 11'h005);
        // Every reduction code, then the override
        for (int i = 0; i < 4; i++) begin
            wr(8'h29, 8'(i << 6));
            chk(red, mv[i]);
        end
        wr(8'h2A, 8'h08);
        chk({10'h000, cmax}, 11'h001);
        chk(red, 11'h000);
        // Pins: carrier level, driver mode, expected second and first pin
        foreach (pin_rows[i]) begin
            @(posedge core_clk_i);
            lvl <= pin_rows[i][8];
            wr(8'h28, pin_rows[i][7:0]);
            @(posedge core_clk_i);
            #1;
            chk({10'h000, en}, {10'h000, pin_rows[i][3]});
            chk({9'h000, p2, p1}, {9'h000, pin_rows[i][1:0]});
        end
        // All source codes with and without inversion, envelope high
        @(posedge core_clk_i);
        env <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(8'h2A, 8'(i));
            @(posedge core_clk_i);
            #1;
            chk({10'h000, mod}, 11'((8'hD2 >> i) & 8'h01));
        end
        // External source after its synchroniser
        wr(8'h2A, 8'h02);
        @(posedge core_clk_i);
        ext <= 1'b1;
        repeat (5) @(posedge core_clk_i);
        #1;
        chk({10'h000, mod}, 11'h001);
        // Reset in mid-run clears the registers
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd(8'h28, 8'h00);
        chk({6'h00, p1, p2, en, cmax, mod}, 11'h000);
        final_report();
    end
endmodule
`default_nettype wire
